// ===== cvs_converter6_seq.sv
/*
  Control, sequencing and hibernate logic for the sixth DC-DC converter,
  with its registers behind an AXI4-Lite slave.
  Assumes one 40 MHz clock, synchronous inputs and a power state machine
  that issues slot pulses, state-entry pulses and a configuration reset.
*/
// Notes on behaviour
// - Capacitor range at 15:14, code 10 unused; bit 11 set disables over-voltage.
// - Disabled converter discharges output when bit 10 clear, floats when set.
// - Seven-bit voltage code, 25 mV steps, 0.85 V up to 3.4 V maximum.
// - Fault action: ignore, shut converter, shut system, reserved shuts system.
// - Every fault raises an interrupt whatever the fault action.
// - Start slot: 0 never, 1-14 in slot, 15 on entering active.
// - Shutdown slot: 1-14 in slot, 0 and 15 on entering off.
// - Hibernate codes 0-3: keep, image voltage, standby, standby with image.
// - Codes 4-5 force LDO mode (with image), 6 reserved, 7 disables output.
// - Trigger select: hibernate bit, or low-power inputs one to three.
// - A GPIO hibernate input forces hibernate regardless of trigger select.
// - Image voltage at 6:0 of low-power register, same coding, default 06.
// - State machine reset restores all configuration fields to defaults.
`include "cvs_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module cvs_converter6_seq
  import cvs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire cvs_psm_s    psm,
  input  wire logic        conv_fault,
  output cvs_ana_s         ana,
  output logic             fault_irq,
  output logic             sys_shutdown
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Clamp a voltage code at the documented ceiling
  function automatic logic [6:0] clamp_volt(input logic [6:0] code);
    clamp_volt = (code > `CVS_VOLT_MAX) ? `CVS_VOLT_MAX : code;
  endfunction

  // Byte-lane merge for a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be, input logic [15:0] mask);
    logic [15:0] m;
    m = old;
    if (be[0]) begin
      m[7:0] = d[7:0];
    end
    if (be[1]) begin
      m[15:8] = d[15:8];
    end
    merge16 = m & mask;
  endfunction

  cvs_state_s q;
  cvs_state_s next_q;

  // ------------------------------------------------------------
  // Decoded fields
  // ------------------------------------------------------------
  logic [3:0] start_slot;
  logic [3:0] stop_slot;
  cvs_fault_e fault_action;
  cvs_hib_e   sleep_behaviour;
  logic [1:0] sleep_trigger_select;
  logic       hib_active;
  logic       image_sel;
  logic       start_now;
  logic       stop_now;
  logic       w_go;

  always_comb begin
    start_slot           = q.slots[`CVS_EN_HI:`CVS_EN_LO];
    stop_slot            = q.slots[`CVS_SD_HI:`CVS_SD_LO];
    fault_action         = cvs_fault_e'(q.slots[`CVS_FAULT_HI:`CVS_FAULT_LO]);
    sleep_behaviour      = cvs_hib_e'(q.low_power[`CVS_HIB_HI:`CVS_HIB_LO]);
    sleep_trigger_select = q.low_power[`CVS_TRIG_HI:`CVS_TRIG_LO];
    case (sleep_trigger_select)
      2'h0: hib_active = psm.hib_reg;
      2'h1: hib_active = psm.low_power[0];
      2'h2: hib_active = psm.low_power[1];
      2'h3: hib_active = psm.low_power[2];
      default: hib_active = 1'b0;
    endcase
    hib_active = hib_active | psm.gpio_hib;
    image_sel  = hib_active && (sleep_behaviour == CVS_HIB_IMG ||
                 sleep_behaviour == CVS_HIB_STBY_IMG ||
                 sleep_behaviour == CVS_HIB_LDO_IMG);
    start_now = (start_slot == `CVS_SLOT_EDGE) ? psm.enter_active :
                (start_slot != `CVS_SLOT_OFF) && psm.slot_pulse && (psm.slot_num == start_slot);
    stop_now = (stop_slot == `CVS_SLOT_EDGE || stop_slot == `CVS_SLOT_OFF) ? psm.enter_off :
               psm.slot_pulse && (psm.slot_num == stop_slot);
    w_go = q.awv && q.wv && !q.bvalid;
  end

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  always_comb begin
    next_q              = q;
    next_q.fault_irq    = 1'b0;
    next_q.sys_shutdown = 1'b0;
    // Sequencing, one step through a transient state each way
    case (q.state)
      CVS_ST_OFF: begin
        if (start_now && !stop_now) begin
          next_q.state = CVS_ST_RAMP;
        end
      end
      CVS_ST_RAMP: begin
        next_q.state = stop_now ? CVS_ST_FALL : CVS_ST_ON;
      end
      CVS_ST_ON: begin
        if (stop_now) begin
          next_q.state = CVS_ST_FALL;
        end
      end
      CVS_ST_FALL: begin
        next_q.state = CVS_ST_OFF;
      end
      default: next_q.state = CVS_ST_OFF;
    endcase
    // Fault handling on the rising edge of the fault level
    if (conv_fault && !q.fault_seen) begin
      next_q.fault_irq = 1'b1;
      case (fault_action)
        CVS_FAULT_IGNORE: ;
        CVS_FAULT_CONV: begin
          next_q.state = (q.state == CVS_ST_OFF) ? CVS_ST_OFF : CVS_ST_FALL;
        end
        CVS_FAULT_SYS, CVS_FAULT_RSVD: begin
          next_q.sys_shutdown = 1'b1;
        end
        default: next_q.sys_shutdown = 1'b1;
      endcase
    end
    next_q.fault_seen = conv_fault;

    // Write channel: address and data taken in either order
    if (!q.awv && s_axi_awvalid) begin
      next_q.awv    = 1'b1;
      next_q.awaddr = s_axi_awaddr;
    end
    if (!q.wv && s_axi_wvalid) begin
      next_q.wv    = 1'b1;
      next_q.wdata = s_axi_wdata;
      next_q.wstrb = s_axi_wstrb;
    end
    if (w_go) begin
      next_q.awv    = 1'b0;
      next_q.wv     = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp  = 2'h0;
      case (q.awaddr)
        `CVS_ADDR_CONTROL:   next_q.control   = merge16(q.control, q.wdata, q.wstrb,
                                                        `CVS_CONTROL_MASK);
        `CVS_ADDR_SLOTS:     next_q.slots     = merge16(q.slots, q.wdata, q.wstrb,
                                                        `CVS_SLOTS_MASK);
        `CVS_ADDR_LOW_POWER: next_q.low_power = merge16(q.low_power, q.wdata, q.wstrb,
                                                        `CVS_LOW_MASK);
        `CVS_ADDR_STATUS:    ;
        default:             next_q.bresp = 2'h2;
      endcase
    end
    if (q.bvalid && s_axi_bready) begin
      next_q.bvalid = 1'b0;
    end

    // Read channel
    if (s_axi_arvalid && !q.rvalid) begin
      next_q.rvalid = 1'b1;
      next_q.rresp  = 2'h0;
      case (s_axi_araddr)
        `CVS_ADDR_CONTROL:   next_q.rdata = {16'h0000, q.control};
        `CVS_ADDR_SLOTS:     next_q.rdata = {16'h0000, q.slots};
        `CVS_ADDR_LOW_POWER: next_q.rdata = {16'h0000, q.low_power};
        `CVS_ADDR_STATUS:    next_q.rdata = {27'h0000000, conv_fault, hib_active,
                                             image_sel, q.state};
        default: begin
          next_q.rdata = 32'h00000000;
          next_q.rresp = 2'h2;
        end
      endcase
    end else if (q.rvalid && s_axi_rready) begin
      next_q.rvalid = 1'b0;
    end

    // Defaults are fixed values; the power state machine restores them
    if (psm.cfg_reset) begin
      next_q.control   = `CVS_RST_CONTROL;
      next_q.slots     = `CVS_RST_SLOTS;
      next_q.low_power = `CVS_RST_LOW_POWER;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q           <= '0;
      q.state     <= CVS_ST_OFF;
      q.control   <= `CVS_RST_CONTROL;
      q.slots     <= `CVS_RST_SLOTS;
      q.low_power <= `CVS_RST_LOW_POWER;
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  logic conv_on;
  assign conv_on       = (q.state == CVS_ST_RAMP || q.state == CVS_ST_ON) &&
                         !(hib_active && sleep_behaviour == CVS_HIB_OFF);
  assign s_axi_awready = !q.awv;
  assign s_axi_wready  = !q.wv;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign fault_irq     = q.fault_irq;
  assign sys_shutdown  = q.sys_shutdown;

  always_comb begin
    ana.enable     = conv_on;
    ana.discharge  = !conv_on && !q.control[`CVS_FLOAT_BIT];
    ana.ovp_enable = !q.control[`CVS_OVP_BIT];
    // Unused capacitor code falls back to the smallest range
    ana.cap_range  = (q.control[`CVS_CAP_HI:`CVS_CAP_LO] == `CVS_CAP_UNUSED) ? 2'h0 :
                     q.control[`CVS_CAP_HI:`CVS_CAP_LO];
    ana.volt_code  = image_sel ? clamp_volt(q.low_power[`CVS_VSEL_HI:0]) :
                     clamp_volt(q.control[`CVS_VSEL_HI:0]);
    ana.standby    = hib_active && (sleep_behaviour == CVS_HIB_STBY ||
                     sleep_behaviour == CVS_HIB_STBY_IMG);
    ana.ldo_mode   = hib_active && (sleep_behaviour == CVS_HIB_LDO ||
                     sleep_behaviour == CVS_HIB_LDO_IMG);
    ana.hib_active = hib_active;
  end

endmodule
`default_nettype wire

// ===== cvs_defs.svh
/*
  Offsets, field positions, reset values and limits of the sixth converter's
  control and sequencing registers.
  Assumes inclusion by bare name from design and verification files.
*/
`ifndef CVS_DEFS_SVH
`define CVS_DEFS_SVH

// ------------------------------------------------------------
// Register byte addresses (index times four)
// ------------------------------------------------------------
`define CVS_IDX_CONTROL    8'hc3
`define CVS_IDX_SLOTS      8'hc4
`define CVS_IDX_LOW_POWER  8'hc5
`define CVS_IDX_STATUS     8'hc6
`define CVS_ADDR_CONTROL   12'h30c
`define CVS_ADDR_SLOTS     12'h310
`define CVS_ADDR_LOW_POWER 12'h314
`define CVS_ADDR_STATUS    12'h318

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define CVS_CAP_HI      15
`define CVS_CAP_LO      14
`define CVS_OVP_BIT     11
`define CVS_FLOAT_BIT   10
`define CVS_VSEL_HI     6
`define CVS_FAULT_HI    15
`define CVS_FAULT_LO    14
`define CVS_EN_HI       13
`define CVS_EN_LO       10
`define CVS_SD_HI       9
`define CVS_SD_LO       6
`define CVS_HIB_HI      14
`define CVS_HIB_LO      12
`define CVS_TRIG_HI     9
`define CVS_TRIG_LO     8

// ------------------------------------------------------------
// Reset values and limits
// ------------------------------------------------------------
`define CVS_RST_CONTROL   16'h0000
`define CVS_RST_SLOTS     16'h0000
`define CVS_RST_LOW_POWER 16'h0006
`define CVS_CONTROL_MASK  16'hcc7f
`define CVS_SLOTS_MASK    16'hffc0
`define CVS_LOW_MASK      16'h737f
`define CVS_VOLT_MAX      7'h66
`define CVS_CAP_UNUSED    2'h2
`define CVS_SLOT_OFF      4'h0
`define CVS_SLOT_EDGE     4'hf

`endif

// ===== cvs_far_model.sv
/*
  Model of the power state machine and fault source facing the block.
  Assumes calls from the bench; every change lands just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module cvs_far_model
  import cvs_pkg::*;
(
  input  wire logic clk,
  output cvs_psm_s  psm,
  output logic      conv_fault
);
  // ----------
  // Stimulus tasks
  // ----------
  initial begin
    psm = '0;
    conv_fault = 1'b0;
  end
  task automatic slot(input logic [3:0] n);
    @(posedge clk);
    psm.slot_pulse <= 1'b1;
    psm.slot_num <= n;
    @(posedge clk);
    psm.slot_pulse <= 1'b0;
  endtask
  // 0 enter active, 1 enter off, 2 configuration reset
  task automatic ev(input int k);
    @(posedge clk);
    psm.enter_active <= (k == 0);
    psm.enter_off <= (k == 1);
    psm.cfg_reset <= (k == 2);
    @(posedge clk);
    psm.enter_active <= 1'b0;
    psm.enter_off <= 1'b0;
    psm.cfg_reset <= 1'b0;
  endtask
  task automatic lvl(input logic h, input logic [2:0] lp, input logic g);
    @(posedge clk);
    psm.hib_reg <= h;
    psm.low_power <= lp;
    psm.gpio_hib <= g;
  endtask
  task automatic fault(input logic v);
    @(posedge clk);
    conv_fault <= v;
  endtask
endmodule
`default_nettype wire

// ===== cvs_pkg.sv
/*
  Types for the converter sequencing block.
  Assumes cvs_defs.svh supplies the numeric constants.
*/
`default_nettype none
package cvs_pkg;

  typedef enum logic [1:0] {
    CVS_FAULT_IGNORE = 2'h0,
    CVS_FAULT_CONV   = 2'h1,
    CVS_FAULT_SYS    = 2'h2,
    CVS_FAULT_RSVD   = 2'h3
  } cvs_fault_e;

  typedef enum logic [2:0] {
    CVS_HIB_KEEP     = 3'h0,
    CVS_HIB_IMG      = 3'h1,
    CVS_HIB_STBY     = 3'h2,
    CVS_HIB_STBY_IMG = 3'h3,
    CVS_HIB_LDO      = 3'h4,
    CVS_HIB_LDO_IMG  = 3'h5,
    CVS_HIB_RSVD     = 3'h6,
    CVS_HIB_OFF      = 3'h7
  } cvs_hib_e;

  // Converter sequencing states, Gray along off -> ramp -> on -> fall
  typedef enum logic [1:0] {
    CVS_ST_OFF  = 2'b00,
    CVS_ST_RAMP = 2'b01,
    CVS_ST_ON   = 2'b11,
    CVS_ST_FALL = 2'b10
  } cvs_state_e;

  // Power state machine view
  typedef struct packed {
    logic       slot_pulse;
    logic [3:0] slot_num;
    logic       enter_active;
    logic       enter_off;
    logic       cfg_reset;
    logic       hib_reg;
    logic [2:0] low_power;
    logic       gpio_hib;
  } cvs_psm_s;

  // Controls toward the analog stage
  typedef struct packed {
    logic       enable;
    logic       discharge;
    logic       ovp_enable;
    logic [1:0] cap_range;
    logic [6:0] volt_code;
    logic       standby;
    logic       ldo_mode;
    logic       hib_active;
  } cvs_ana_s;

  typedef struct packed {
    logic [15:0] control;
    logic [15:0] slots;
    logic [15:0] low_power;
    cvs_state_e  state;
    logic        fault_seen;
    logic        awv;
    logic [11:0] awaddr;
    logic        wv;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        fault_irq;
    logic        sys_shutdown;
  } cvs_state_s;

endpackage
`default_nettype wire

// ===== cvs_seq_chk.sv
/*
  Port assertions for the sixth converter sequencing block.
  Assumes clk_en held high and attachment by the bind at the foot.
*/
`timescale 1ns/1ps
`default_nettype none
module cvs_seq_chk
  import cvs_pkg::*;
(
  input wire logic     clk,
  input wire logic     resetn,
  input wire cvs_psm_s psm,
  input wire logic     conv_fault,
  input wire cvs_ana_s ana,
  input wire logic     fault_irq,
  input wire logic     sys_shutdown
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_fault_rise;
    !conv_fault ##1 conv_fault;
  endsequence
  sequence s_irq_once;
    fault_irq ##1 !fault_irq;
  endsequence
  property p_irq;      s_fault_rise |=> s_irq_once; endproperty
  property p_sys;      sys_shutdown |-> fault_irq; endproperty
  property p_cap;      ana.cap_range != 2'h2; endproperty
  property p_volt;     ana.volt_code <= 7'h66; endproperty
  property p_dis;      ana.enable |-> !ana.discharge; endproperty
  // Hibernate exits also raise enable, so only quiet cycles are judged
  property p_start;
    $rose(ana.enable) && !ana.hib_active && !$past(ana.hib_active)
      |-> $past(psm.slot_pulse || psm.enter_active);
  endproperty
  property p_gpio;     psm.gpio_hib |-> ana.hib_active; endproperty
  property p_no_hib;
    !psm.gpio_hib && !psm.hib_reg && psm.low_power == 3'h0 |-> !ana.hib_active;
  endproperty
  property p_mode;     ana.standby || ana.ldo_mode |-> ana.hib_active; endproperty
  a_irq:    assert property (p_irq)    else $error("fault irq not one pulse");
  a_sys:    assert property (p_sys)    else $error("shutdown without irq");
  a_cap:    assert property (p_cap)    else $error("unused cap code out");
  a_volt:   assert property (p_volt)   else $error("voltage above max");
  a_dis:    assert property (p_dis)    else $error("discharge while on");
  a_start:  assert property (p_start)  else $error("start without event");
  a_gpio:   assert property (p_gpio)   else $error("gpio hib ignored");
  a_no_hib: assert property (p_no_hib) else $error("hib with no source");
  a_mode:   assert property (p_mode)   else $error("mode outside hib");
endmodule
bind cvs_converter6_seq cvs_seq_chk u_chk (
  .clk(clk), .resetn(resetn), .psm(psm), .conv_fault(conv_fault),
  .ana(ana), .fault_irq(fault_irq), .sys_shutdown(sys_shutdown));
`default_nettype wire

// ===== tb.sv
/*
  Self-checking bench for the sixth converter sequencing block.
  Assumes the far-side model and an AXI4-Lite master built from tasks.
*/
`include "cvs_defs.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("MISMATCH %s expected %h seen %h", n, e, a); end end
module tb;
  import cvs_pkg::*;
  logic        clk, resetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, conv_fault, fault_irq, sys_shutdown;
  logic        clk_en;
  logic [3:0]  wstrb;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  cvs_psm_s    psm;
  cvs_ana_s    ana;
  int          bad_count, n_checks, n_irq, n_sd;
  logic [3:0]  st [5] = '{4'h1, 4'he, 4'hf, 4'h7, 4'h0};
  logic [3:0]  sd [5] = '{4'he, 4'h1, 4'h0, 4'hf, 4'h3};
  cvs_converter6_seq uut (.clk(clk), .resetn(resetn), .clk_en(clk_en),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .psm(psm), .conv_fault(conv_fault), .ana(ana), .fault_irq(fault_irq),
    .sys_shutdown(sys_shutdown));
  cvs_far_model m (.clk(clk), .psm(psm), .conv_fault(conv_fault));
  // ----------
  // Bus tasks
  // ----------
  // Handshakes are judged at the rising edge, on values settled before it
  task automatic wreg(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ta, tw, db;
    db = 1'b0;
    @(posedge clk);
    awaddr <= a; awvalid <= 1'b1; wdata <= {16'h0, d}; wvalid <= 1'b1; bready <= 1'b1;
    while (!db) begin
      @(posedge clk);
      ta = awvalid & awready; tw = wvalid & wready; db = bvalid & bready;
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (db) `CHK("bresp", er, bresp)
    end
    bready <= 1'b0;
  endtask
  task automatic rreg(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
    logic ta, dr;
    dr = 1'b0;
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (!dr) begin
      @(posedge clk);
      ta = arvalid & arready; dr = rvalid & rready;
      if (ta) arvalid <= 1'b0;
      if (dr) `CHK("rdata", e, rdata)
      if (dr) `CHK("rresp", er, rresp)
    end
    rready <= 1'b0;
  endtask
  task automatic ctl(input logic [15:0] d, input logic [1:0] c, input logic o,
                     input logic [6:0] v, input logic ds);
    wreg(`CVS_ADDR_CONTROL, d, 2'h0);
    @(negedge clk);
    `CHK("cap", c, ana.cap_range)
    `CHK("ovp", o, ana.ovp_enable)
    `CHK("volt", v, ana.volt_code)
    `CHK("disch", ds, ana.discharge)
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------
  // Tests
  // ----------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    #(25 * 20000);
    bad_count++;
    results();
  end
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    clk_en = 1'b1;
    wstrb = 4'hf;
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    rreg(`CVS_ADDR_CONTROL, 32'h0, 2'h0);
    rreg(`CVS_ADDR_LOW_POWER, 32'h6, 2'h0);
    wreg(`CVS_ADDR_SLOTS, 16'hffff, 2'h0);
    rreg(`CVS_ADDR_SLOTS, 32'hffc0, 2'h0);
    wreg(12'h400, 16'h1, 2'h2);
    rreg(12'h400, 32'h0, 2'h2);
    wstrb <= 4'h1;
    wreg(`CVS_ADDR_CONTROL, 16'hffff, 2'h0);
    wstrb <= 4'hf;
    rreg(`CVS_ADDR_CONTROL, 32'h7f, 2'h0);
    $display("test registers done");
    ctl(16'h807f, 2'h0, 1'b1, 7'h66, 1'b1);
    ctl(16'hc826, 2'h3, 1'b0, 7'h26, 1'b1);
    ctl(16'h4400, 2'h1, 1'b1, 7'h00, 1'b0);
    $display("test control done");
    for (int i = 0; i < 5; i++) begin
      wreg(`CVS_ADDR_SLOTS, {2'h0, st[i], sd[i], 6'h0}, 2'h0);
      m.slot(st[i] ^ 4'h1);
      @(negedge clk);
      `CHK("early", 1'b0, ana.enable)
      if (st[i] == 4'hf) m.ev(0); else m.slot(st[i]);
      @(negedge clk);
      `CHK("start", st[i] != 4'h0, ana.enable)
      if (sd[i] == 4'h0 || sd[i] == 4'hf) m.ev(1); else m.slot(sd[i]);
      @(negedge clk);
      `CHK("stop", 1'b0, ana.enable)
    end
    wreg(`CVS_ADDR_SLOTS, 16'h0480, 2'h0);
    clk_en <= 1'b0;
    m.slot(4'h1);
    @(negedge clk);
    `CHK("frozen", 1'b0, ana.enable)
    clk_en <= 1'b1;
    $display("test sequencing done");
    ctl(16'h0026, 2'h0, 1'b1, 7'h26, 1'b1);
    wreg(`CVS_ADDR_SLOTS, 16'h0480, 2'h0);
    m.slot(4'h1);
    m.lvl(1'b1, 3'h0, 1'b0);
    for (int c = 0; c < 8; c++) begin
      wreg(`CVS_ADDR_LOW_POWER, {1'b0, 3'(c), 4'h0, 8'h0e}, 2'h0);
      @(negedge clk);
      `CHK("img", (c % 2 == 1 && c < 6) ? 7'h0e : 7'h26, ana.volt_code)
      `CHK("stby", c == 2 || c == 3, ana.standby)
      `CHK("ldo", c == 4 || c == 5, ana.ldo_mode)
      `CHK("en", c != 7, ana.enable)
    end
    wreg(`CVS_ADDR_LOW_POWER, 16'h100e, 2'h0);
    m.lvl(1'b0, 3'h0, 1'b0);
    @(negedge clk);
    `CHK("main", 7'h26, ana.volt_code)
    for (int t = 0; t < 4; t++) begin
      wreg(`CVS_ADDR_LOW_POWER, {6'h0, 2'(t), 8'h06}, 2'h0);
      m.lvl(t != 0, (t == 0) ? 3'h7 : ~(3'h1 << (t - 1)), 1'b0);
      @(negedge clk);
      `CHK("unsel", 1'b0, ana.hib_active)
      m.lvl(t == 0, (t == 0) ? 3'h0 : (3'h1 << (t - 1)), 1'b0);
      @(negedge clk);
      `CHK("sel", 1'b1, ana.hib_active)
    end
    m.lvl(1'b0, 3'h0, 1'b1);
    @(negedge clk);
    `CHK("gpio", 1'b1, ana.hib_active)
    m.lvl(1'b0, 3'h0, 1'b0);
    m.slot(4'h2);
    $display("test hibernate done");
    for (int a = 0; a < 4; a++) begin
      wreg(`CVS_ADDR_SLOTS, {2'(a), 14'h0480}, 2'h0);
      m.slot(4'h1);
      m.fault(1'b1);
      n_irq = 0;
      n_sd = 0;
      repeat (4) begin
        @(negedge clk);
        n_irq += fault_irq;
        n_sd += sys_shutdown;
      end
      `CHK("irq", 1, n_irq)
      `CHK("sysdn", (a >= 2) ? 1 : 0, n_sd)
      if (a < 2) `CHK("fen", a == 0, ana.enable)
      m.fault(1'b0);
      m.slot(4'h2);
    end
    $display("test faults done");
    wreg(`CVS_ADDR_CONTROL, 16'h0c26, 2'h0);
    m.ev(2);
    rreg(`CVS_ADDR_CONTROL, 32'h0, 2'h0);
    rreg(`CVS_ADDR_LOW_POWER, 32'h6, 2'h0);
    $display("test config reset done");
    results();
  end
endmodule
`default_nettype wire
